//--- hw/mgr_params.svh
// Constants of the magnetometer register bank: indices, field positions, reset values
`ifndef MGR_PARAMS_SVH
`define MGR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------------
`define MGR_IDX_CHIP_IDENTITY        8'h40
`define MGR_IDX_RESERVED_SLOT        8'h41
`define MGR_IDX_FIELD_X_LOW          8'h42
`define MGR_IDX_FIELD_X_HIGH         8'h43
`define MGR_IDX_FIELD_Y_LOW          8'h44
`define MGR_IDX_FIELD_Y_HIGH         8'h45
`define MGR_IDX_FIELD_Z_LOW          8'h46
`define MGR_IDX_FIELD_Z_HIGH         8'h47
`define MGR_IDX_HALL_LOW             8'h48
`define MGR_IDX_HALL_HIGH            8'h49
`define MGR_IDX_INTERRUPT_FLAGS      8'h4A
`define MGR_IDX_POWER_AND_RESET      8'h4B
`define MGR_IDX_OPERATION_RATE       8'h4C
`define MGR_IDX_INTERRUPT_ENABLES    8'h4D
`define MGR_IDX_PIN_AND_AXIS         8'h4E
`define MGR_IDX_LOW_LIMIT            8'h4F
`define MGR_IDX_HIGH_LIMIT           8'h50
`define MGR_IDX_XY_REPEAT            8'h51
`define MGR_IDX_Z_REPEAT             8'h52

// ----------------------------------------------------------------------------
// Field positions of the power and reset control register
// ----------------------------------------------------------------------------
`define MGR_PWR_ON_BIT               0
`define MGR_SOFT_RESET_LOW_BIT       1
`define MGR_SPI3_BIT                 2
`define MGR_SOFT_RESET_HIGH_BIT      7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MGR_RST_POWER_ON             1'b1
`define MGR_RST_OPERATION_RATE       8'h06
`define MGR_RST_INTERRUPT_ENABLES    8'h3F
`define MGR_RST_PIN_AND_AXIS         8'h07
`define MGR_RST_ZERO_BYTE            8'h00
`define MGR_RST_SELFTEST             1'b1

// ----------------------------------------------------------------------------
// Sample layout: x 13, y 13, z 15, hall 14 bits
// ----------------------------------------------------------------------------
`define MGR_X_WIDTH                  13
`define MGR_Y_WIDTH                  13
`define MGR_Z_WIDTH                  15
`define MGR_HALL_WIDTH               14

`endif

//--- hw/mgr_pkg.sv
// Types shared by the magnetometer register bank
`default_nettype none
package mgr_pkg;

  // --------------------------------------------------------------------------
  // State of the bus slave and control registers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] readData;
    logic       slaveError;
    logic       powerOn;
    logic       spi3Wire;
    logic [7:0] operationRate;
    logic [7:0] interruptEnables;
    logic [7:0] pinAndAxis;
    logic [7:0] lowLimit;
    logic [7:0] highLimit;
    logic [7:0] xyRepeat;
    logic [7:0] zRepeat;
    logic       softResetPulse;
    logic       pairPending;
  } mgr_state_type;

endpackage : mgr_pkg
`default_nettype wire

//--- hw/mgr_sample_latch.sv
// Holding register for one complete field sample, frozen while a pair is being read
`timescale 1ns/10ps
`default_nettype none
module mgr_sample_latch #(
  parameter int          WIDTH     = 59,
  parameter [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              sampleValid,
  input  wire logic              holdSample,
  input  wire logic [WIDTH-1:0]  sampleIn,
  output logic      [WIDTH-1:0]  sampleHeld
);
  typedef struct packed {
    logic [WIDTH-1:0] held;
  } mgr_latch_state_type;

  mgr_latch_state_type s_q;
  mgr_latch_state_type s_d;

  // A sample arriving while the host is between low and high byte is dropped
  always_comb begin
    s_d = s_q;
    if (sampleValid && !holdSample) begin
      s_d.held = sampleIn;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q.held <= RESET_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign sampleHeld = s_q.held;

  chk_frozen_sample: assert property (@(posedge mclk) disable iff (!resetn)
    holdSample |=> $stable(sampleHeld))
    else $error("held sample changed while frozen");
endmodule : mgr_sample_latch
`default_nettype wire

//--- hw/mgr_register_bank.sv
// APB register bank of a three-axis magnetometer
//
// Overview of operation
// - The identity register returns its value only while the power bit (bit 0 of power) is one, else zero.
// - A read-only eight-bit identity register sits at index 0x40 and holds a fixed identity value.
// - Low x carries x bits 4..0 in bits 7..3, x bit 0 in bit 3, and bits 2 and 1 read zero.
// - Bit 0 of low x is the x self-test flag, which reads one by default.
// - High x carries x bits 12..5 in bits 7..0, bit 7 being the top bit.
// - The thirteen-bit x sample is high x at index 0x43 joined with the five data bits of low x.
// - Index 0x41 is reserved and has no function.
// - A soft reset starts only when bits 7 and 1 of power are both written as one.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "mgr_params.svh"
module mgr_register_bank #(
  parameter int        ADDR_WIDTH    = 12,
  parameter logic [7:0] CHIP_IDENTITY = 8'h5A  // Arbitrary value
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sampleValid,
  input  wire logic [12:0]            xField,
  input  wire logic [12:0]            yField,
  input  wire logic [14:0]            zField,
  input  wire logic [13:0]            hallField,
  input  wire logic                   xSelfTest,
  input  wire logic                   ySelfTest,
  input  wire logic                   zSelfTest,
  input  wire logic                   dataReady,
  input  wire logic [7:0]             interruptFlags,
  output logic                        powerOn,
  output logic                        spi3Wire,
  output logic                        softResetPulse,
  output logic      [7:0]             operationRate,
  output logic      [7:0]             interruptEnables,
  output logic      [7:0]             pinAndAxis,
  output logic      [7:0]             lowLimit,
  output logic      [7:0]             highLimit,
  output logic      [7:0]             xyRepeat,
  output logic      [7:0]             zRepeat
);
  import mgr_pkg::*;

  // --------------------------------------------------------------------------
  // Held sample
  // --------------------------------------------------------------------------
  localparam int SAMPLE_W = `MGR_X_WIDTH + `MGR_Y_WIDTH + `MGR_Z_WIDTH + `MGR_HALL_WIDTH + 4;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = {{(SAMPLE_W-4){1'b0}},
                                                `MGR_RST_SELFTEST, `MGR_RST_SELFTEST, `MGR_RST_SELFTEST, 1'b0};

  mgr_state_type          s_q;
  mgr_state_type          s_d;
  logic [SAMPLE_W-1:0]    sampleHeld;
  logic [12:0]            heldX;
  logic [12:0]            heldY;
  logic [14:0]            heldZ;
  logic [13:0]            heldHall;
  logic                   heldStX;
  logic                   heldStY;
  logic                   heldStZ;
  logic                   heldReady;
  logic [7:0]             regIndex;
  logic                   addrInRange;
  logic                   setupPhase;
  logic                   writeAccess;
  logic [7:0]             wByte;
  logic                   freezeSample;

  // All axes live in one latch so that every low/high pair comes from one sample
  mgr_sample_latch #(
    .WIDTH     (SAMPLE_W),
    .RESET_VAL (SAMPLE_RST)
  ) u_mgr_sample_latch (
    .mclk        (mclk),
    .resetn      (resetn),
    .sampleValid (sampleValid),
    .holdSample  (freezeSample),
    .sampleIn    ({xField, yField, zField, hallField, xSelfTest, ySelfTest, zSelfTest, dataReady}),
    .sampleHeld  (sampleHeld)
  );

  assign {heldX, heldY, heldZ, heldHall, heldStX, heldStY, heldStZ, heldReady} = sampleHeld;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign regIndex    = paddr[9:2];
  assign addrInRange = (paddr[1:0] == 2'b00) && (paddr >> 10 == '0) &&
                       (regIndex >= `MGR_IDX_CHIP_IDENTITY) && (regIndex <= `MGR_IDX_Z_REPEAT);
  assign setupPhase  = psel && !penable;
  assign writeAccess = psel && penable && pwrite && !s_q.slaveError;
  assign wByte       = pwdata[7:0];

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  function automatic logic [7:0] readByte(input logic [7:0] idx, input mgr_state_type st);
    logic [7:0] value;
    value = 8'h00;
    case (idx)
      `MGR_IDX_CHIP_IDENTITY:     value = st.powerOn ? CHIP_IDENTITY : 8'h00;
      `MGR_IDX_RESERVED_SLOT:     value = 8'h00;
      `MGR_IDX_FIELD_X_LOW:       value = {heldX[4:0], 2'b00, heldStX};
      `MGR_IDX_FIELD_X_HIGH:      value = heldX[12:5];
      `MGR_IDX_FIELD_Y_LOW:       value = {heldY[4:0], 2'b00, heldStY};
      `MGR_IDX_FIELD_Y_HIGH:      value = heldY[12:5];
      `MGR_IDX_FIELD_Z_LOW:       value = {heldZ[6:0], heldStZ};
      `MGR_IDX_FIELD_Z_HIGH:      value = heldZ[14:7];
      `MGR_IDX_HALL_LOW:          value = {heldHall[5:0], 1'b0, heldReady};
      `MGR_IDX_HALL_HIGH:         value = heldHall[13:6];
      `MGR_IDX_INTERRUPT_FLAGS:   value = interruptFlags;
      // Soft reset bits clear themselves and always read zero
      `MGR_IDX_POWER_AND_RESET:   value = {5'h00, st.spi3Wire, 1'b0, st.powerOn};
      `MGR_IDX_OPERATION_RATE:    value = st.operationRate;
      `MGR_IDX_INTERRUPT_ENABLES: value = st.interruptEnables;
      `MGR_IDX_PIN_AND_AXIS:      value = st.pinAndAxis;
      `MGR_IDX_LOW_LIMIT:         value = st.lowLimit;
      `MGR_IDX_HIGH_LIMIT:        value = st.highLimit;
      `MGR_IDX_XY_REPEAT:         value = st.xyRepeat;
      `MGR_IDX_Z_REPEAT:          value = st.zRepeat;
      default:                    value = 8'h00;
    endcase
    return value;
  endfunction : readByte

  function automatic logic isLowField(input logic [7:0] idx);
    return (idx == `MGR_IDX_FIELD_X_LOW) || (idx == `MGR_IDX_FIELD_Y_LOW) ||
           (idx == `MGR_IDX_FIELD_Z_LOW) || (idx == `MGR_IDX_HALL_LOW);
  endfunction : isLowField

  function automatic logic isHighField(input logic [7:0] idx);
    return (idx == `MGR_IDX_FIELD_X_HIGH) || (idx == `MGR_IDX_FIELD_Y_HIGH) ||
           (idx == `MGR_IDX_FIELD_Z_HIGH) || (idx == `MGR_IDX_HALL_HIGH);
  endfunction : isHighField

  // Freeze from the low read's own setup edge, else a sample landing there splits the pair
  assign freezeSample = s_q.pairPending ||
                        (setupPhase && !pwrite && addrInRange && isLowField(regIndex));

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d                = s_q;
    s_d.softResetPulse = 1'b0;
    // Answer is prepared in the setup cycle so the access cycle needs no wait
    if (setupPhase) begin
      s_d.slaveError = !addrInRange;
      s_d.readData   = addrInRange ? readByte(regIndex, s_q) : 8'h00;
      if (!pwrite && addrInRange && isLowField(regIndex)) begin
        s_d.pairPending = 1'b1;
      end else if (!pwrite && addrInRange && isHighField(regIndex)) begin
        s_d.pairPending = 1'b0;
      end else if (pwrite) begin
        s_d.pairPending = 1'b0;
      end
    end
    if (writeAccess) begin
      case (regIndex)
        `MGR_IDX_POWER_AND_RESET: begin
          s_d.powerOn  = wByte[`MGR_PWR_ON_BIT];
          s_d.spi3Wire = wByte[`MGR_SPI3_BIT];
          // Ignored while suspended; both bits must be one together
          s_d.softResetPulse = wByte[`MGR_SOFT_RESET_HIGH_BIT] &&
                               wByte[`MGR_SOFT_RESET_LOW_BIT] && s_q.powerOn;
        end
        `MGR_IDX_OPERATION_RATE:    s_d.operationRate    = wByte;
        `MGR_IDX_INTERRUPT_ENABLES: s_d.interruptEnables = wByte;
        `MGR_IDX_PIN_AND_AXIS:      s_d.pinAndAxis       = wByte;
        `MGR_IDX_LOW_LIMIT:         s_d.lowLimit         = wByte;
        `MGR_IDX_HIGH_LIMIT:        s_d.highLimit        = wByte;
        `MGR_IDX_XY_REPEAT:         s_d.xyRepeat         = wByte;
        `MGR_IDX_Z_REPEAT:          s_d.zRepeat          = wByte;
        default: begin
        end
      endcase
    end
    // Soft reset restores every control register except the power register
    if (s_q.softResetPulse) begin
      s_d.operationRate    = `MGR_RST_OPERATION_RATE;
      s_d.interruptEnables = `MGR_RST_INTERRUPT_ENABLES;
      s_d.pinAndAxis       = `MGR_RST_PIN_AND_AXIS;
      s_d.lowLimit         = `MGR_RST_ZERO_BYTE;
      s_d.highLimit        = `MGR_RST_ZERO_BYTE;
      s_d.xyRepeat         = `MGR_RST_ZERO_BYTE;
      s_d.zRepeat          = `MGR_RST_ZERO_BYTE;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q.readData         <= `MGR_RST_ZERO_BYTE;
      s_q.slaveError       <= 1'b0;
      s_q.powerOn          <= `MGR_RST_POWER_ON;
      s_q.spi3Wire         <= 1'b0;
      s_q.operationRate    <= `MGR_RST_OPERATION_RATE;
      s_q.interruptEnables <= `MGR_RST_INTERRUPT_ENABLES;
      s_q.pinAndAxis       <= `MGR_RST_PIN_AND_AXIS;
      s_q.lowLimit         <= `MGR_RST_ZERO_BYTE;
      s_q.highLimit        <= `MGR_RST_ZERO_BYTE;
      s_q.xyRepeat         <= `MGR_RST_ZERO_BYTE;
      s_q.zRepeat          <= `MGR_RST_ZERO_BYTE;
      s_q.softResetPulse   <= 1'b0;
      s_q.pairPending      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata           = {24'h00_0000, s_q.readData};
  assign pready           = psel && penable;
  assign pslverr          = psel && penable && s_q.slaveError;
  assign powerOn          = s_q.powerOn;
  assign spi3Wire         = s_q.spi3Wire;
  assign softResetPulse   = s_q.softResetPulse;
  assign operationRate    = s_q.operationRate;
  assign interruptEnables = s_q.interruptEnables;
  assign pinAndAxis       = s_q.pinAndAxis;
  assign lowLimit         = s_q.lowLimit;
  assign highLimit        = s_q.highLimit;
  assign xyRepeat         = s_q.xyRepeat;
  assign zRepeat          = s_q.zRepeat;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic        readSetup;
  logic [12:0] xAtLowRead;
  assign readSetup = setupPhase && !pwrite && addrInRange;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      xAtLowRead <= 13'h0000;
    end else if (readSetup && isLowField(regIndex)) begin
      xAtLowRead <= heldX;
    end
  end

  sequence lowXRead;
    readSetup && regIndex == `MGR_IDX_FIELD_X_LOW;
  endsequence

  sequence highXReadAfterLow;
    readSetup && regIndex == `MGR_IDX_FIELD_X_HIGH && s_q.pairPending;
  endsequence

  chk_id_gated_off: assert property (
    (readSetup && regIndex == `MGR_IDX_CHIP_IDENTITY && !s_q.powerOn) |=> prdata == 32'h0000_0000)
    else $error("identity visible while power bit clear");

  chk_id_value_on: assert property (
    (readSetup && regIndex == `MGR_IDX_CHIP_IDENTITY && s_q.powerOn) |=> prdata[7:0] == CHIP_IDENTITY)
    else $error("identity register wrong while powered");

  chk_xlow_layout: assert property (
    lowXRead |=> prdata[7:3] == $past(heldX[4:0]) && prdata[2:1] == 2'b00)
    else $error("low x field bits misplaced");

  chk_selftest_flag: assert property (
    lowXRead |=> prdata[0] == $past(heldStX))
    else $error("x self-test flag not in bit 0");

  chk_xhigh_layout: assert property (
    (readSetup && regIndex == `MGR_IDX_FIELD_X_HIGH) |=> prdata[7:0] == $past(heldX[12:5]))
    else $error("high x field bits misplaced");

  chk_pair_same_sample: assert property (
    highXReadAfterLow |-> heldX == xAtLowRead)
    else $error("high x read from another sample than low x");

  chk_reserved_slot: assert property (
    (readSetup && regIndex == `MGR_IDX_RESERVED_SLOT) |=> prdata == 32'h0000_0000 && !pslverr)
    else $error("reserved index not quiet");

  chk_soft_reset_start: assert property (
    (writeAccess && regIndex == `MGR_IDX_POWER_AND_RESET) |=>
      softResetPulse == ($past(wByte[`MGR_SOFT_RESET_HIGH_BIT]) && $past(wByte[`MGR_SOFT_RESET_LOW_BIT])
                         && $past(s_q.powerOn)) ##1 !softResetPulse)
    else $error("soft reset start wrong");

  chk_soft_reset_effect: assert property (
    softResetPulse |=> operationRate == `MGR_RST_OPERATION_RATE && zRepeat == `MGR_RST_ZERO_BYTE)
    else $error("soft reset did not restore controls");

  chk_pair_hold: assert property (
    lowXRead ##1 (!readSetup) [*2] |-> $stable(heldX))
    else $error("x sample changed between pair reads");

  chk_unmapped_err: assert property (
    (setupPhase && !addrInRange) |=> pslverr)
    else $error("unmapped address without error");

  chk_freeze_at_read: assert property (
    lowXRead |=> $stable(heldX))
    else $error("x sample changed at low read");

  chk_pair_release: assert property (
    (setupPhase && pwrite) |=> !s_q.pairPending)
    else $error("write did not release frozen sample");

  chk_power_bit: assert property (
    (writeAccess && regIndex == `MGR_IDX_POWER_AND_RESET) |=> powerOn == $past(wByte[`MGR_PWR_ON_BIT]))
    else $error("power bit not written");

  chk_reset_bits_zero: assert property (
    (readSetup && regIndex == `MGR_IDX_POWER_AND_RESET) |=> prdata[7] == 1'b0 && prdata[1] == 1'b0)
    else $error("soft reset bits read back");

  chk_read_data_holds: assert property (
    !setupPhase |=> $stable(prdata))
    else $error("read data moved outside setup");

  chk_write_refused: assert property (
    (psel && penable && pwrite && s_q.slaveError && !softResetPulse) |=> $stable(operationRate))
    else $error("refused write changed a register");

  chk_ylow_layout: assert property (
    (readSetup && regIndex == `MGR_IDX_FIELD_Y_LOW) |=> prdata[7:3] == $past(heldY[4:0]) && prdata[2:1] == 2'b00)
    else $error("low y field bits misplaced");

  chk_zlow_layout: assert property (
    (readSetup && regIndex == `MGR_IDX_FIELD_Z_LOW) |=> prdata[7:0] == {$past(heldZ[6:0]), $past(heldStZ)})
    else $error("low z field bits misplaced");

  chk_hall_low_gap: assert property (
    (readSetup && regIndex == `MGR_IDX_HALL_LOW) |=> prdata[1] == 1'b0)
    else $error("hall low gap bit set");

endmodule : mgr_register_bank
`default_nettype wire

//--- verification/mgr_core_model.sv
// Sensor core stand-in that hands complete field samples to the register bank
`timescale 1ns/10ps
`default_nettype none
module mgr_core_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        fire,
  input  wire logic [12:0] xNext,
  input  wire logic        stNext,
  output logic             sampleValid,
  output logic      [12:0] xField,
  output logic      [12:0] yField,
  output logic      [14:0] zField,
  output logic      [13:0] hallField,
  output logic             selfTest,
  output logic             dataReady
);
  // Outside the strobe the lines show the inverse, so a capture at the wrong cycle shows up
  always_ff @(posedge mclk) begin
    sampleValid <= resetn & fire;
    xField      <= fire ? xNext : ~xNext;
    yField      <= fire ? (xNext ^ 13'h1FFF) : xNext;
    zField      <= fire ? {xNext, 2'b10} : ~{xNext, 2'b10};
    hallField   <= fire ? {xNext, 1'b1} : ~{xNext, 1'b1};
    selfTest    <= fire ? stNext : ~stNext;
    dataReady   <= fire ? ~stNext : stNext;
  end
endmodule : mgr_core_model
`default_nettype wire

//--- verification/mgr_register_bank_tb_top.sv
// Self-checking bench of the magnetometer register bank over APB
`timescale 1ns/10ps
`default_nettype none
`include "mgr_params.svh"
module mgr_register_bank_tb_top;
  localparam logic [7:0] ID_VALUE = 8'hA7;  // Arbitrary value
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, fire, stNext;
  logic        sampleValid, selfTest, dataReady, powerOn, spi3Wire, softResetPulse, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] xNext, xField, yField;
  logic [14:0] zField;
  logic [13:0] hallField;
  logic [7:0]  intFlags, opRate, intEn, pinAxis, lowLim, highLim, xyRep, zRep;
  logic [55:0] ctrlRst, ctrlWr;
  int          numErrors, checksDone, pulseCount;
  assign ctrlRst = {`MGR_RST_OPERATION_RATE, `MGR_RST_INTERRUPT_ENABLES, `MGR_RST_PIN_AND_AXIS, 32'h0000_0000};

  mgr_core_model u_mgr_core_model (.mclk(mclk), .resetn(resetn), .fire(fire), .xNext(xNext), .stNext(stNext),
    .sampleValid(sampleValid), .xField(xField), .yField(yField), .zField(zField), .hallField(hallField),
    .selfTest(selfTest), .dataReady(dataReady));
  mgr_register_bank #(.ADDR_WIDTH(12), .CHIP_IDENTITY(ID_VALUE)) u_mgr_register_bank (.mclk(mclk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid), .xField(xField),
    .yField(yField), .zField(zField), .hallField(hallField), .xSelfTest(selfTest), .ySelfTest(selfTest),
    .zSelfTest(selfTest), .dataReady(dataReady), .interruptFlags(intFlags), .powerOn(powerOn),
    .spi3Wire(spi3Wire), .softResetPulse(softResetPulse), .operationRate(opRate), .interruptEnables(intEn),
    .pinAndAxis(pinAxis), .lowLimit(lowLim), .highLimit(highLim), .xyRepeat(xyRep), .zRepeat(zRep));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // A pulse is counted once per cycle that it stands
  always @(posedge mclk) begin
    if (softResetPulse === 1'b1) pulseCount++;
  end

  task report_and_stop;
    if (numErrors == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= addr; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      numErrors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ad

  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, ad(idx), 32'h0000_0000);
    check(64'({err, rd}), 64'({1'b0, 24'h00_0000, exp}));
  endtask : rd_chk

  task fire_sample(input logic [12:0] x, input logic st);
    @(posedge mclk);
    fire <= 1'b1; xNext <= x; stNext <= st;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : fire_sample

  // Byte layout that each field register must show for a given sample
  function automatic logic [7:0] exp_byte(input logic [7:0] idx, input logic [12:0] x, input logic st);
    logic [12:0] y;
    logic [14:0] z;
    logic [13:0] h;
    y = x ^ 13'h1FFF;
    z = {x, 2'b10};
    h = {x, 1'b1};
    case (idx)
      8'h42:   return {x[4:0], 2'b00, st};
      8'h43:   return x[12:5];
      8'h44:   return {y[4:0], 2'b00, st};
      8'h45:   return y[12:5];
      8'h46:   return {z[6:0], st};
      8'h47:   return z[14:7];
      8'h48:   return {h[5:0], 1'b0, ~st};
      default: return h[13:6];
    endcase
  endfunction : exp_byte

  initial begin
    logic [11:0] bad [4];
    bad = '{ad(8'h3F), 12'h131, ad(8'h53), 12'h500};
    numErrors = 0; checksDone = 0; pulseCount = 0;
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    fire = 1'b0; xNext = '0; stNext = 1'b0; intFlags = 8'hC5; ctrlWr = '0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    // ----------------------------------------------------------------------
    // Identity, held sample and status after reset
    // ----------------------------------------------------------------------
    rd_chk(`MGR_IDX_CHIP_IDENTITY, ID_VALUE);
    rd_chk(8'h42, 8'h01);
    rd_chk(8'h43, 8'h00);
    rd_chk(8'h46, 8'h01);
    rd_chk(`MGR_IDX_INTERRUPT_FLAGS, 8'hC5);
    apb(1'b1, ad(8'h41), 32'h0000_00FF);
    check(64'(err), 64'd0);
    rd_chk(8'h41, 8'h00);
    apb(1'b1, ad(8'h40), 32'h0000_0011);
    rd_chk(8'h40, ID_VALUE);
    for (int i = 0; i < 4; i++) begin
      apb(1'(i), bad[i], 32'h0000_00FF);
      check(64'({err, rd}), 64'({1'b1, 32'h0000_0000}));
    end
    // ----------------------------------------------------------------------
    // Field layout and pair consistency
    // ----------------------------------------------------------------------
    fire_sample(13'h1A5B, 1'b0);
    for (int i = 8'h42; i <= 8'h49; i++) rd_chk(8'(i), exp_byte(8'(i), 13'h1A5B, 1'b0));
    fire_sample(13'h0F3C, 1'b1);
    rd_chk(8'h42, exp_byte(8'h42, 13'h0F3C, 1'b1));
    fire_sample(13'h10A5, 1'b0);
    rd_chk(8'h43, exp_byte(8'h43, 13'h0F3C, 1'b1));
    fire_sample(13'h10A5, 1'b0);
    rd_chk(8'h42, exp_byte(8'h42, 13'h10A5, 1'b0));
    rd_chk(8'h43, exp_byte(8'h43, 13'h10A5, 1'b0));
    // A new sample lands exactly at the low read's setup edge and must not split the pair
    @(posedge mclk);
    fire <= 1'b1; xNext <= 13'h0A0A; stNext <= 1'b1;
    rd_chk(8'h42, exp_byte(8'h42, 13'h10A5, 1'b0));
    rd_chk(8'h43, exp_byte(8'h43, 13'h10A5, 1'b0));
    fire <= 1'b0;
    rd_chk(8'h43, exp_byte(8'h43, 13'h0A0A, 1'b1));
    // ----------------------------------------------------------------------
    // Control registers, then soft reset only on both bits with power on
    // ----------------------------------------------------------------------
    check(64'({opRate, intEn, pinAxis, lowLim, highLim, xyRep, zRep}), 64'(ctrlRst));
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'(8'h4C + i), ctrlRst[55 - 8 * i -: 8]);
      apb(1'b1, ad(8'(8'h4C + i)), 32'hFFFF_FF00 | 32'(8'h91 + i));
      rd_chk(8'(8'h4C + i), 8'(8'h91 + i));
      ctrlWr = {ctrlWr[47:0], 8'(8'h91 + i)};
    end
    check(64'({opRate, intEn, pinAxis, lowLim, highLim, xyRep, zRep}), 64'(ctrlWr));
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0081);
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0003);
    repeat (2) @(posedge mclk);
    check(64'(pulseCount), 64'd0);
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0083);
    repeat (2) @(posedge mclk);
    check(64'(pulseCount), 64'd1);
    check(64'({powerOn, opRate, intEn, pinAxis, lowLim, highLim, xyRep, zRep}), 64'({1'b1, ctrlRst}));
    rd_chk(`MGR_IDX_POWER_AND_RESET, 8'h01);
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0005);
    rd_chk(`MGR_IDX_POWER_AND_RESET, 8'h05);
    check(64'(spi3Wire), 64'd1);
    // Power off hides the identity and blocks soft reset
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0000);
    rd_chk(`MGR_IDX_CHIP_IDENTITY, 8'h00);
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0082);
    repeat (2) @(posedge mclk);
    check(64'(pulseCount), 64'd1);
    apb(1'b1, ad(`MGR_IDX_POWER_AND_RESET), 32'h0000_0001);
    rd_chk(`MGR_IDX_CHIP_IDENTITY, ID_VALUE);
    report_and_stop();
  end
endmodule : mgr_register_bank_tb_top
`default_nettype wire
